// [hdl/cba_cfg.svh]
// Constants of the bus auxiliary signal block: reset values, widths and timing counts.
// Assumes a 100 MHz double-rate clock from which the system clock is divided by two.
`ifndef CBA_CFG_SVH
`define CBA_CFG_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CBA_CLK_PERIOD_PS 10000
`define CBA_TC_LOW_HALF_SYS 3
`define CBA_TC_PULSE_CLKS ((`CBA_TC_LOW_HALF_SYS * 2 * `CBA_CLK_PERIOD_PS) / (2 * `CBA_CLK_PERIOD_PS))

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define CBA_CNT_W 5
`define CBA_TIMER_W 24
`define CBA_INT_IDLE 3'h7
`define CBA_LANE_IDLE 2'h3
`define CBA_MODE_RST 6'h3f

`endif

// [hdl/cba_pkg.sv]
// Types of the bus auxiliary signal block.
// Assumes cba_cfg.svh is on the include path.
`include "cba_cfg.svh"
package cba_pkg;

	// ****************************************************************
	// Transfer request from the bus interface unit
	// ****************************************************************
	typedef struct packed {
		logic isRead;
		logic [1:0] byteLane;
		logic [`CBA_CNT_W-1:0] datumCount;
	} cba_xfer_req_t;

	// ****************************************************************
	// Pins that face the bus, all active-low except systemRefClock
	// ****************************************************************
	typedef struct packed {
		logic readStrobe_n;
		logic writeStrobe_n;
		logic [1:0] halfwordLaneStrobe_n;
		logic lastDatum_n;
		logic timerTerminalCount_n;
		logic busGrantOut_n;
		logic systemRefClock;
	} cba_pins_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ADDR = 3'b010,
		ST_DATA = 3'b100
	} cba_state_t;

	typedef enum logic [1:0] {
		TM_RUN = 2'b01,
		TM_HOLD = 2'b10
	} cba_tstate_t;

endpackage

// [hdl/cba_sync2.sv]
// Two flip-flop synchroniser for pins from outside the clock domain.
// Assumes a synchronous active-high reset on the local clock.
`timescale 1ns/10ps
module cba_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '1
)(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb
	begin
		meta_d = asyncIn;
		sync_d = meta_q;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign syncOut = sync_q;
endmodule

// [hdl/cba_timer.sv]
// On-chip down-counting timer with terminal-count output.
// Assumes tick is a one-clock pulse once per system clock.
`timescale 1ns/10ps
`include "cba_cfg.svh"
module cba_timer #(
	parameter int TW = `CBA_TIMER_W,
	parameter int PULSE_CLKS = `CBA_TC_PULSE_CLKS
)(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic tick,
	input wire logic softMode,
	input wire logic softReset,
	input wire logic [TW-1:0] reloadValue,
	output logic tcActive
);
	cba_pkg::cba_tstate_t st_q;
	cba_pkg::cba_tstate_t st_d;
	logic [TW-1:0] cnt_q;
	logic [TW-1:0] cnt_d;
	logic [3:0] pulse_q;
	logic [3:0] pulse_d;

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		pulse_d = pulse_q;
		case (st_q)
			cba_pkg::TM_RUN:
			begin
				if (tick)
				begin
					if (cnt_q == '0)
					begin
						cnt_d = reloadValue;
						st_d = cba_pkg::TM_HOLD;
						pulse_d = 4'(PULSE_CLKS - 1);
					end
					else
					begin
						cnt_d = cnt_q - 1'b1;
					end
				end
			end
			cba_pkg::TM_HOLD:
			begin
				if (softMode)
				begin
					if (softReset)
					begin
						st_d = cba_pkg::TM_RUN;
					end
				end
				else if (pulse_q == 4'h0)
				begin
					st_d = cba_pkg::TM_RUN;
				end
				else
				begin
					pulse_d = pulse_q - 1'b1;
					if (tick && cnt_q != '0)
					begin
						cnt_d = cnt_q - 1'b1;
					end
				end
			end
			default:
			begin
				st_d = cba_pkg::TM_RUN;
			end
		endcase
		if (softMode && softReset)
		begin
			cnt_d = reloadValue;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_q <= cba_pkg::TM_RUN;
			cnt_q <= '0;
			pulse_q <= 4'h0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			pulse_q <= pulse_d;
		end
	end

	assign tcActive = (st_q == cba_pkg::TM_HOLD);
endmodule

// [hdl/cba_aux_signals.sv]
// Auxiliary bus control signals: lane strobes, final-datum flag, terminal count,
// bus fault handling, interrupt and mode inputs, output float and system clock.
// Assumes clk is the double-rate master clock and the core logic shares it.
`timescale 1ns/10ps
`include "cba_cfg.svh"
module cba_aux_signals #(
	parameter int CW = `CBA_CNT_W,
	parameter int TW = `CBA_TIMER_W
)(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic xferStart,
	input wire cba_pkg::cba_xfer_req_t xferReq,
	output logic xferReady,
	output logic xferDone,
	output logic busErrorException,
	input wire logic maskReadLanes,
	input wire logic timerSoftMode,
	input wire logic timerSoftReset,
	input wire logic [TW-1:0] timerReload,
	input wire logic busGrantReq,
	output logic [5:0] interruptLevel,
	output logic [5:0] resetMode,
	input wire logic ackIn_n,
	input wire logic readBufferLoad_n,
	input wire logic busFaultIn_n,
	input wire logic [2:0] syncedInterruptIn_n,
	input wire logic [2:0] directInterruptIn_n,
	input wire logic floatAllOutputsReq_n,
	output cba_pkg::cba_pins_t pinOut,
	output logic pinOutEn
);
	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [2:0] ctlSync;
	logic [2:0] sIntSync;
	logic [2:0] dIntSync;
	logic floatSync_n;

	cba_sync2 #(.W(3), .RST_VAL(3'h7)) ctlSyncInst (
		.clk(clk),
		.sys_rst(sys_rst),
		.asyncIn({ackIn_n, readBufferLoad_n, busFaultIn_n}),
		.syncOut(ctlSync)
	);

	cba_sync2 #(.W(3), .RST_VAL(`CBA_INT_IDLE)) sIntSyncInst (
		.clk(clk),
		.sys_rst(1'b0),
		.asyncIn(syncedInterruptIn_n),
		.syncOut(sIntSync)
	);

	cba_sync2 #(.W(3), .RST_VAL(`CBA_INT_IDLE)) dIntSyncInst (
		.clk(clk),
		.sys_rst(1'b0),
		.asyncIn(directInterruptIn_n),
		.syncOut(dIntSync)
	);

	cba_sync2 #(.W(1), .RST_VAL(1'b1)) floatSyncInst (
		.clk(clk),
		.sys_rst(sys_rst),
		.asyncIn(floatAllOutputsReq_n),
		.syncOut(floatSync_n)
	);

	logic ackSeen;
	logic loadSeen;
	logic faultSeen;

	assign ackSeen = ~ctlSync[2];
	assign loadSeen = ~ctlSync[1];
	assign faultSeen = ~ctlSync[0];

	// ****************************************************************
	// System clock divider
	// ****************************************************************
	logic phase_q;
	logic phase_d;
	logic sysTick;

	always_comb
	begin
		phase_d = ~phase_q;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			phase_q <= 1'b0;
		end
		else
		begin
			phase_q <= phase_d;
		end
	end

	assign sysTick = ~phase_q;

	// ****************************************************************
	// Interrupt path and reset mode capture
	// ****************************************************************
	logic [2:0] sIntStage_q;
	logic [2:0] sIntStage_d;
	logic [5:0] intLevel_q;
	logic [5:0] intLevel_d;
	logic [5:0] mode_q;
	logic [5:0] mode_d;

	always_comb
	begin
		sIntStage_d = sIntStage_q;
		intLevel_d = intLevel_q;
		mode_d = mode_q;
		if (sysTick)
		begin
			sIntStage_d = ~sIntSync;
			intLevel_d = {~dIntSync, sIntStage_q};
		end
		if (sys_rst)
		begin
			mode_d = ~{dIntSync, sIntSync};
		end
	end

	always_ff @(posedge clk)
	begin
		mode_q <= mode_d;
		if (sys_rst)
		begin
			sIntStage_q <= 3'h0;
			intLevel_q <= 6'h00;
		end
		else
		begin
			sIntStage_q <= sIntStage_d;
			intLevel_q <= intLevel_d;
		end
	end

	assign interruptLevel = intLevel_q;
	assign resetMode = mode_q;

	// ****************************************************************
	// Transaction sequencer
	// ****************************************************************
	cba_pkg::cba_state_t st_q;
	cba_pkg::cba_state_t st_d;
	cba_pkg::cba_xfer_req_t req_q;
	cba_pkg::cba_xfer_req_t req_d;
	logic [CW-1:0] remain_q;
	logic [CW-1:0] remain_d;
	logic done_q;
	logic done_d;
	logic berr_q;
	logic berr_d;
	logic datumEvent;

	assign xferReady = (st_q == cba_pkg::ST_IDLE);
	assign datumEvent = req_q.isRead ? loadSeen : ackSeen;

	always_comb
	begin
		st_d = st_q;
		req_d = req_q;
		remain_d = remain_q;
		done_d = 1'b0;
		berr_d = 1'b0;
		case (st_q)
			cba_pkg::ST_IDLE:
			begin
				if (xferStart)
				begin
					req_d = xferReq;
					remain_d = (xferReq.datumCount == '0) ? CW'(1) : xferReq.datumCount;
					st_d = cba_pkg::ST_ADDR;
				end
			end
			cba_pkg::ST_ADDR:
			begin
				if (sysTick)
				begin
					st_d = cba_pkg::ST_DATA;
				end
			end
			cba_pkg::ST_DATA:
			begin
				if (sysTick)
				begin
					if (faultSeen)
					begin
						st_d = cba_pkg::ST_IDLE;
						done_d = 1'b1;
						berr_d = req_q.isRead;
					end
					else if (datumEvent)
					begin
						if (remain_q == CW'(1))
						begin
							st_d = cba_pkg::ST_IDLE;
							done_d = 1'b1;
						end
						else
						begin
							remain_d = remain_q - 1'b1;
						end
					end
				end
			end
			default:
			begin
				st_d = cba_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_q <= cba_pkg::ST_IDLE;
			req_q <= '0;
			remain_q <= '0;
			done_q <= 1'b0;
			berr_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			req_q <= req_d;
			remain_q <= remain_d;
			done_q <= done_d;
			berr_q <= berr_d;
		end
	end

	assign xferDone = done_q;
	assign busErrorException = berr_q;

	// ****************************************************************
	// Timer
	// ****************************************************************
	logic tcActive;

	cba_timer #(.TW(TW)) timerInst (
		.clk(clk),
		.sys_rst(sys_rst),
		.tick(sysTick),
		.softMode(timerSoftMode),
		.softReset(timerSoftReset),
		.reloadValue(timerReload),
		.tcActive(tcActive)
	);

	// ****************************************************************
	// Registered pin outputs
	// ****************************************************************
	cba_pkg::cba_pins_t pins_q;
	cba_pkg::cba_pins_t pins_d;
	logic oe_q;
	logic oe_d;
	logic inData;

	assign inData = (st_d == cba_pkg::ST_DATA);

	always_comb
	begin
		pins_d.readStrobe_n = ~(inData && req_d.isRead);
		pins_d.writeStrobe_n = ~(inData && !req_d.isRead);
		pins_d.halfwordLaneStrobe_n = `CBA_LANE_IDLE;
		if (inData && !(req_d.isRead && maskReadLanes))
		begin
			pins_d.halfwordLaneStrobe_n[1] = ~req_d.byteLane[1];
			pins_d.halfwordLaneStrobe_n[0] = ~req_d.byteLane[0];
		end
		pins_d.lastDatum_n = ~(inData && remain_d == CW'(1));
		pins_d.timerTerminalCount_n = ~tcActive;
		pins_d.busGrantOut_n = ~busGrantReq;
		pins_d.systemRefClock = phase_d;
		oe_d = floatSync_n;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pins_q <= '{readStrobe_n: 1'b1, writeStrobe_n: 1'b1, halfwordLaneStrobe_n: `CBA_LANE_IDLE,
				lastDatum_n: 1'b1, timerTerminalCount_n: 1'b1, busGrantOut_n: 1'b1,
				systemRefClock: 1'b0};
			oe_q <= 1'b1;
		end
		else
		begin
			pins_q <= pins_d;
			oe_q <= oe_d;
		end
	end

	assign pinOut = pins_q;
	assign pinOutEn = oe_q;
endmodule

// [sim/cba_aux_signals_checker.sv]
// Concurrent checks on the ports of the auxiliary bus signal block.
// Assumes one clock clk and synchronous active-high reset sys_rst.
`timescale 1ns/10ps
module cba_aux_signals_checker #(
	parameter int CW = 5,
	parameter int TW = 24
)(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic xferStart,
	input wire cba_pkg::cba_xfer_req_t xferReq,
	input wire logic xferReady,
	input wire logic xferDone,
	input wire logic busErrorException,
	input wire logic maskReadLanes,
	input wire logic timerSoftMode,
	input wire logic timerSoftReset,
	input wire logic floatAllOutputsReq_n,
	input wire cba_pkg::cba_pins_t pinOut,
	input wire logic pinOutEn
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ****************************************************************
	// Request capture
	// ****************************************************************
	logic isRead_q, isRead_d;
	logic [1:0] lane_q, lane_d;
	logic act, masked, tcN;
	assign act = !pinOut.readStrobe_n || !pinOut.writeStrobe_n;
	assign masked = isRead_q && maskReadLanes;
	assign tcN = pinOut.timerTerminalCount_n;
	always_comb
	begin
		isRead_d = isRead_q;
		lane_d = lane_q;
		if (xferStart && xferReady)
		begin
			isRead_d = xferReq.isRead;
			lane_d = xferReq.byteLane;
		end
	end
	always_ff @(posedge clk)
	begin
		isRead_q <= isRead_d;
		lane_q <= lane_d;
	end
	// ****************************************************************
	// Properties
	// ****************************************************************
	property p_upper;
		act && !masked |-> pinOut.halfwordLaneStrobe_n[1] == !lane_q[1];
	endproperty
	a_upper: assert property (p_upper) else $error("upper lane strobe wrong");
	property p_lower;
		act && !masked |-> pinOut.halfwordLaneStrobe_n[0] == !lane_q[0];
	endproperty
	a_lower: assert property (p_lower) else $error("lower lane strobe wrong");
	property p_mask;
		act && masked |-> pinOut.halfwordLaneStrobe_n == 2'h3;
	endproperty
	a_mask: assert property (p_mask) else $error("masked read lane active");
	property p_last;
		!act |-> pinOut.lastDatum_n;
	endproperty
	a_last: assert property (p_last) else $error("final flag outside strobe");
	property p_tcFree;
		$fell(tcN) && !timerSoftMode |-> !tcN [*3] ##1 tcN;
	endproperty
	a_tcFree: assert property (p_tcFree) else $error("terminal count pulse width");
	property p_tcSoft;
		timerSoftMode && !tcN && !timerSoftReset && !$past(timerSoftReset) |=> !tcN;
	endproperty
	a_tcSoft: assert property (p_tcSoft) else $error("held terminal count dropped");
	property p_rst;
		disable iff (1'b0) sys_rst |=> pinOut.lastDatum_n && tcN && pinOutEn;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	property p_exc;
		busErrorException |-> xferDone && isRead_q;
	endproperty
	a_exc: assert property (p_exc) else $error("exception without read end");
	property p_float;
		$fell(floatAllOutputsReq_n) |-> ##[1:4] !pinOutEn;
	endproperty
	a_float: assert property (p_float) else $error("outputs not floated");
	property p_system_ref_clock;
		!$past(sys_rst) |-> pinOut.systemRefClock != $past(pinOut.systemRefClock);
	endproperty
	a_system_ref_clock: assert property (p_system_ref_clock) else $error("system clock not halved");
	c_read: cover property (xferDone && isRead_q);
	c_write: cover property (xferDone && !isRead_q);
	c_exc: cover property (busErrorException);
	c_tc: cover property ($fell(tcN));
endmodule
bind cba_aux_signals cba_aux_signals_checker #(.CW(CW), .TW(TW)) chk (.clk(clk), .sys_rst(sys_rst),
	.xferStart(xferStart), .xferReq(xferReq), .xferReady(xferReady), .xferDone(xferDone),
	.busErrorException(busErrorException), .maskReadLanes(maskReadLanes), .timerSoftMode(timerSoftMode),
	.timerSoftReset(timerSoftReset), .floatAllOutputsReq_n(floatAllOutputsReq_n), .pinOut(pinOut),
	.pinOutEn(pinOutEn));

// [sim/cba_mem_model.sv]
// Memory controller model answering each datum with a two-clock low window.
// Assumes strobes from the block; slow and fault come from the bench.
`timescale 1ns/10ps
module cba_mem_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire cba_pkg::cba_pins_t pins,
	input wire logic slow,
	input wire logic fault,
	input wire logic faultNow,
	output logic ackIn_n,
	output logic readBufferLoad_n,
	output logic busFaultIn_n,
	output int respCnt,
	output int lastCnt
);
	int wt = 0;
	int gap;
	initial
	begin
		ackIn_n = 1'b1;
		readBufferLoad_n = 1'b1;
		busFaultIn_n = 1'b1;
		respCnt = 0;
		lastCnt = 0;
	end
	// Lane strobes are not used by this port model
	assign gap = slow ? 20 : 6;
	always @(posedge clk)
	begin
		ackIn_n <= 1'b1;
		readBufferLoad_n <= 1'b1;
		busFaultIn_n <= !faultNow;
		wt <= 0;
		if (!sys_rst && (!pins.readStrobe_n || !pins.writeStrobe_n))
		begin
			wt <= (wt == gap + 1) ? 0 : wt + 1;
			if (wt >= gap && fault)
				busFaultIn_n <= 1'b0;
			else if (wt >= gap && !pins.readStrobe_n)
				readBufferLoad_n <= 1'b0;
			else if (wt >= gap)
				ackIn_n <= 1'b0;
			if (wt == gap && !fault)
			begin
				respCnt <= respCnt + 1;
				lastCnt <= lastCnt + int'(!pins.lastDatum_n);
			end
		end
	end
endmodule

// [sim/cba_aux_signals_bench.sv]
// Self-checking bench for the auxiliary bus signal block.
// Assumes the checker is bound and the memory model answers each datum.
`timescale 1ns/10ps
module cba_aux_signals_bench;
	logic clk = 0, sys_rst = 1, xferStart = 0, maskReadLanes = 0, timerSoftMode = 0, timerSoftReset = 0;
	logic busGrantReq = 0, floatAllOutputsReq_n = 1, slow = 0, fault = 0, faultNow = 0;
	logic ackIn_n, readBufferLoad_n, busFaultIn_n, xferReady, xferDone, busErrorException, pinOutEn;
	logic [2:0] syncedInterruptIn_n = 3'h3, directInterruptIn_n = 3'h5;
	logic [23:0] timerReload = 24'h000004;
	logic [5:0] interruptLevel, resetMode;
	cba_pkg::cba_xfer_req_t xferReq = '0;
	cba_pkg::cba_pins_t pinOut;
	int err_count = 0, checks = 0, respCnt, lastCnt, n;
	cba_aux_signals DUT (.clk(clk), .sys_rst(sys_rst), .xferStart(xferStart), .xferReq(xferReq),
		.xferReady(xferReady), .xferDone(xferDone), .busErrorException(busErrorException),
		.maskReadLanes(maskReadLanes), .timerSoftMode(timerSoftMode), .timerSoftReset(timerSoftReset),
		.timerReload(timerReload), .busGrantReq(busGrantReq), .interruptLevel(interruptLevel),
		.resetMode(resetMode), .ackIn_n(ackIn_n), .readBufferLoad_n(readBufferLoad_n),
		.busFaultIn_n(busFaultIn_n), .syncedInterruptIn_n(syncedInterruptIn_n),
		.directInterruptIn_n(directInterruptIn_n), .floatAllOutputsReq_n(floatAllOutputsReq_n),
		.pinOut(pinOut), .pinOutEn(pinOutEn));
	cba_mem_model mem (.clk(clk), .sys_rst(sys_rst), .pins(pinOut), .slow(slow), .fault(fault),
		.faultNow(faultNow), .ackIn_n(ackIn_n), .readBufferLoad_n(readBufferLoad_n),
		.busFaultIn_n(busFaultIn_n), .respCnt(respCnt), .lastCnt(lastCnt));
	initial
	begin
		forever #5 clk = ~clk;
	end
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task compare(input logic [23:0] got, input logic [23:0] exp, input string msg);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask
	task stop_test;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task t_xfer(input logic rd, input logic [1:0] ln, input logic [4:0] cnt, input logic flt);
		int r0, l0;
		r0 = respCnt;
		l0 = lastCnt;
		for (int i = 0; i < 100 && xferReady !== 1'b1; i++) @(negedge clk);
		fault = flt;
		xferReq = '{rd, ln, cnt};
		xferStart = 1'b1;
		@(negedge clk);
		xferStart = 1'b0;
		for (int i = 0; i < 300 && xferDone !== 1'b1; i++) @(negedge clk);
		compare(24'(xferDone), 24'h1, "transfer did not end");
		compare(24'(busErrorException), 24'(rd & flt), "exception");
		compare(24'(respCnt - r0), flt ? 24'h0 : 24'(cnt), "datum count");
		compare(24'(lastCnt - l0), flt ? 24'h0 : 24'h1, "final flag");
		@(negedge clk);
		fault = 1'b0;
	endtask
	task t_idle_fault;
		n = 0;
		faultNow = 1'b1;
		repeat (10)
		begin
			@(negedge clk);
			n += int'(busErrorException | xferDone);
		end
		faultNow = 1'b0;
		compare(24'(n), 24'h0, "fault while idle");
		repeat (4) @(negedge clk);
		t_xfer(1'b1, 2'h1, 5'h01, 1'b0);
	endtask
	task t_irq;
		int d, s;
		d = 0;
		s = 0;
		directInterruptIn_n = 3'h6;
		syncedInterruptIn_n = 3'h6;
		for (int i = 0; i < 20; i++)
		begin
			@(negedge clk);
			d += int'(interruptLevel[3] !== 1'b1);
			s += int'(interruptLevel[0] !== 1'b1);
		end
		compare(24'(s - d), 24'h2, "interrupt latency");
		compare(24'(interruptLevel), 24'h09, "interrupt level");
		directInterruptIn_n = 3'h7;
		syncedInterruptIn_n = 3'h7;
	endtask
	task t_timer;
		n = 0;
		repeat (100)
		begin
			@(negedge clk);
			n += int'(!pinOut.timerTerminalCount_n);
		end
		compare(24'(n >= 6), 24'h1, "free timer pulses");
		for (int i = 0; i < 50 && pinOut.timerTerminalCount_n !== 1'b0; i++) @(negedge clk);
		for (int i = 0; i < 50 && pinOut.timerTerminalCount_n !== 1'b1; i++) @(negedge clk);
		timerSoftMode = 1'b1;
		for (int i = 0; i < 50 && pinOut.timerTerminalCount_n !== 1'b0; i++) @(negedge clk);
		repeat (20) @(negedge clk);
		compare(24'(pinOut.timerTerminalCount_n), 24'h0, "held count");
		timerSoftReset = 1'b1;
		@(negedge clk);
		timerSoftReset = 1'b0;
		timerSoftMode = 1'b0;
		repeat (2) @(negedge clk);
		compare(24'(pinOut.timerTerminalCount_n), 24'h1, "count released");
	endtask
	task t_float;
		floatAllOutputsReq_n = 1'b0;
		busGrantReq = 1'b1;
		repeat (5) @(negedge clk);
		compare(24'(pinOutEn), 24'h0, "float");
		compare(24'(pinOut.busGrantOut_n), 24'h0, "bus grant");
		floatAllOutputsReq_n = 1'b1;
		busGrantReq = 1'b0;
		repeat (5) @(negedge clk);
		compare(24'(pinOutEn), 24'h1, "drive again");
	endtask
	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial
	begin
		repeat (6) @(negedge clk);
		compare(24'(interruptLevel), 24'h00, "level in reset");
		sys_rst = 1'b0;
		@(negedge clk);
		directInterruptIn_n = 3'h7;
		syncedInterruptIn_n = 3'h7;
		repeat (4) @(negedge clk);
		compare(24'(resetMode), 24'h14, "reset mode");
		t_xfer(1'b1, 2'h3, 5'h01, 1'b0);
		t_xfer(1'b1, 2'h2, 5'h02, 1'b0);
		slow = 1'b1;
		t_xfer(1'b0, 2'h1, 5'h04, 1'b0);
		slow = 1'b0;
		t_xfer(1'b0, 2'h3, 5'h03, 1'b0);
		maskReadLanes = 1'b1;
		t_xfer(1'b1, 2'h3, 5'h02, 1'b0);
		maskReadLanes = 1'b0;
		t_xfer(1'b1, 2'h3, 5'h02, 1'b1);
		t_xfer(1'b0, 2'h3, 5'h02, 1'b1);
		t_idle_fault();
		t_irq();
		t_timer();
		t_float();
		stop_test();
	end
	initial
	begin
		#50000;
		err_count++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		stop_test();
	end
endmodule
